// >>> shared/sdct_pkg.sv
// package for the sdram cycle timing block: commands, latencies, pin groups
// assumes one device clock; controller signals arrive from outside the domain
package sdct_pkg;
    localparam int SDCT_DW = 32;
    localparam int SDCT_NB = 4;
    // command encodings {ras_n, cas_n, we_n} with chip select low
    localparam logic [2:0] SDCT_C_NOP = 3'h7;
    localparam logic [2:0] SDCT_C_ACT = 3'h3;
    localparam logic [2:0] SDCT_C_RD = 3'h5;
    localparam logic [2:0] SDCT_C_WR = 3'h4;
    localparam logic [2:0] SDCT_C_STOP = 3'h6;
    localparam logic [2:0] SDCT_C_PRE = 3'h2;
    localparam logic [2:0] SDCT_C_REF = 3'h1;
    localparam logic [2:0] SDCT_C_LMR = 3'h0;
    // cycle figures
    localparam int SDCT_CCD = 1;
    localparam int SDCT_SUSPEND_ENTRY_LAG = 1;
    localparam int SDCT_SUSPEND_EXIT_LAG = 1;
    localparam int SDCT_WRITE_DATA_LAG = 0;
    localparam int SDCT_DQM_WR_LAG = 0;
    localparam int SDCT_DQM_RD_LAG = 2;
    localparam int SDCT_HIZ_LAT3 = 3;
    localparam int SDCT_HIZ_LAT2 = 2;
    localparam int SDCT_LAT_MAX = 3;
    localparam logic [1:0] SDCT_LAT_TWO = 2'h2;
    localparam logic [1:0] SDCT_LAT_THREE = 2'h3;
    localparam logic [1:0] SDCT_LAT_RESET = 2'h3;
    localparam int SDCT_LAT_LSB = 4;
    localparam int SDCT_MODE_W = 12;
    localparam logic [SDCT_MODE_W-1:0] SDCT_MODE_RESET = 12'h030;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bank;
        logic [SDCT_MODE_W-1:0] addr;
    } sdct_cmd_t;

    typedef struct packed {
        logic [SDCT_DW-1:0] dq;
        logic [SDCT_NB-1:0] dqm;
    } sdct_data_t;
endpackage : sdct_pkg

// >>> hw/sdct_core.sv
// sdram cycle timing core: command decode, suspend, data and mask latencies
// assumes controller pins arrive asynchronously and are synchronised here;
// the array itself is outside: reads come in as rd_word, writes leave as
// wr_word with a per-byte strobe
// Operation
// - column command accepted every cycle
// - clock enable low suspends one cycle later
// - clock enable high resumes one cycle later
// - write byte mask acts same edge
// - mask affects input data with zero delay
// - read byte mask floats byte two later
// - first write word taken with command
// - new column command one cycle after
// - precharge floats read data three/two later
// - chip select high means no operation
module sdct_core
    import sdct_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire sdct_pkg::sdct_cmd_t cmd_pin,
    input wire logic cke_pin,
    input wire sdct_pkg::sdct_data_t din_pin,
    input wire logic [SDCT_DW-1:0] rd_word,
    output logic [SDCT_DW-1:0] dq_out,
    output logic [SDCT_NB-1:0] dq_oe_n,
    output logic [SDCT_DW-1:0] wr_word,
    output logic [SDCT_NB-1:0] wr_strobe,
    output logic rd_req,
    output logic suspended,
    output logic [1:0] read_latency
);
    import sdct_pkg::*;

    // two-stage synchronisers; first stage read only by second
    sdct_cmd_t cmd_s1_ff, cmd_ff;
    sdct_data_t din_s1_ff, din_ff;
    logic cke_s1_ff, cke_ff;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cmd_s1_ff <= '1;
            cmd_ff <= '1;
            din_s1_ff <= '0;
            din_ff <= '0;
            cke_s1_ff <= 1'b1;
            cke_ff <= 1'b1;
        end
        else
        begin
            cmd_s1_ff <= cmd_pin;
            cmd_ff <= cmd_s1_ff;
            din_s1_ff <= din_pin;
            din_ff <= din_s1_ff;
            cke_s1_ff <= cke_pin;
            cke_ff <= cke_s1_ff;
        end
    end

    function automatic logic [2:0] decode(input sdct_cmd_t c);
        if (c.cs_n)
            return SDCT_C_NOP;
        return {c.ras_n, c.cas_n, c.we_n};
    endfunction : decode

    // clock enable: sampled low now means suspended from the next cycle
    logic susp_ff, nxt_susp;
    logic active;
    always_comb
    begin
        nxt_susp = ~cke_ff;
    end
    assign active = ~susp_ff;

    logic [2:0] op;
    assign op = active ? decode(cmd_ff) : SDCT_C_NOP;

    // read pipeline: request now, data from the array one cycle later,
    // output after read_latency; mask shifts by the mask lag
    logic [1:0] lat_ff, nxt_lat;
    logic wr_burst_ff, nxt_wr_burst;
    logic [SDCT_LAT_MAX:0] rd_vld_ff, nxt_rd_vld;
    logic [SDCT_NB-1:0] mask_d1_ff, mask_d2_ff, nxt_mask_d1, nxt_mask_d2;
    logic [SDCT_DW-1:0] dq_out_ff, nxt_dq_out;
    logic [SDCT_NB-1:0] oe_n_ff, nxt_oe_n;
    logic [SDCT_DW-1:0] wr_word_ff, nxt_wr_word;
    logic [SDCT_NB-1:0] wr_strobe_ff, nxt_wr_strobe;
    logic rd_req_ff, nxt_rd_req;
    logic [SDCT_DW-1:0] rd_hold_ff, nxt_rd_hold;
    // read pipeline taps at which a word leaves
    localparam int TAP_TWO = int'(SDCT_LAT_TWO) - 1;
    localparam int TAP_THREE = int'(SDCT_LAT_THREE) - 1;

    always_comb
    begin
        nxt_lat = lat_ff;
        nxt_wr_burst = wr_burst_ff;
        nxt_rd_vld = rd_vld_ff;
        nxt_mask_d1 = mask_d1_ff;
        nxt_mask_d2 = mask_d2_ff;
        nxt_dq_out = dq_out_ff;
        nxt_oe_n = oe_n_ff;
        nxt_wr_word = wr_word_ff;
        nxt_wr_strobe = '0;
        nxt_rd_req = 1'b0;
        if (active)
        begin
            nxt_rd_vld = {rd_vld_ff[SDCT_LAT_MAX-1:0], 1'b0};
            nxt_mask_d1 = din_ff.dqm;
            nxt_mask_d2 = mask_d1_ff;
            unique case (op)
                SDCT_C_LMR:
                    nxt_lat = cmd_ff.addr[SDCT_LAT_LSB +: 2];
                SDCT_C_RD:
                begin
                    nxt_rd_req = 1'b1;
                    nxt_rd_vld[0] = 1'b1;
                    nxt_wr_burst = 1'b0;
                end
                SDCT_C_WR:
                    nxt_wr_burst = 1'b1;
                SDCT_C_STOP:
                    nxt_wr_burst = 1'b0;
                SDCT_C_PRE:
                begin
                    // words already asked for still come out, so
                    // the pins float read_latency cycles after this
                    nxt_wr_burst = 1'b0;
                end
                default:
                    nxt_wr_burst = wr_burst_ff;
            endcase
            // data and mask taken on the command edge itself
            if (op == SDCT_C_WR || (wr_burst_ff && op == SDCT_C_NOP))
            begin
                nxt_wr_word = din_ff.dq;
                nxt_wr_strobe = ~din_ff.dqm;
            end
            // output stage
            if (lat_ff == SDCT_LAT_TWO && rd_vld_ff[TAP_TWO])
            begin
                nxt_dq_out = rd_word;
                nxt_oe_n = mask_d2_ff;
            end
            else if (lat_ff == SDCT_LAT_THREE && rd_vld_ff[TAP_THREE])
            begin
                nxt_dq_out = rd_hold_ff;
                nxt_oe_n = mask_d2_ff;
            end
            else
                nxt_oe_n = '1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            susp_ff <= 1'b0;
            lat_ff <= SDCT_LAT_RESET;
            wr_burst_ff <= 1'b0;
            rd_vld_ff <= '0;
            mask_d1_ff <= '0;
            mask_d2_ff <= '0;
            dq_out_ff <= '0;
            oe_n_ff <= '1;
            wr_word_ff <= '0;
            wr_strobe_ff <= '0;
            rd_req_ff <= 1'b0;
        end
        else
        begin
            susp_ff <= nxt_susp;
            lat_ff <= nxt_lat;
            wr_burst_ff <= nxt_wr_burst;
            rd_vld_ff <= nxt_rd_vld;
            mask_d1_ff <= nxt_mask_d1;
            mask_d2_ff <= nxt_mask_d2;
            dq_out_ff <= nxt_dq_out;
            oe_n_ff <= nxt_oe_n;
            wr_word_ff <= nxt_wr_word;
            wr_strobe_ff <= nxt_wr_strobe;
            rd_req_ff <= nxt_rd_req;
        end
    end

    // array word stands one cycle only; latency three needs it one longer
    always_comb
    begin
        nxt_rd_hold = rd_hold_ff;
        if (active && rd_vld_ff[TAP_TWO])
        begin
            nxt_rd_hold = rd_word;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rd_hold_ff <= '0;
        end
        else
        begin
            rd_hold_ff <= nxt_rd_hold;
        end
    end

    assign dq_out = dq_out_ff;
    assign dq_oe_n = oe_n_ff;
    assign wr_word = wr_word_ff;
    assign wr_strobe = wr_strobe_ff;
    assign rd_req = rd_req_ff;
    assign suspended = susp_ff;
    assign read_latency = lat_ff;
endmodule : sdct_core

// >>> testbench/sdct_chk.sv
// checker: pin-to-port cycle figures of the timing core
// assumes two sync stages ahead of every pin
module sdct_chk (
    input logic clk_sys,
    input logic rst,
    input sdct_pkg::sdct_cmd_t cmd_pin,
    input logic cke_pin,
    input sdct_pkg::sdct_data_t din_pin,
    input logic [3:0] dq_oe_n,
    input logic [3:0] wr_strobe,
    input logic rd_req,
    input logic suspended,
    input logic [1:0] read_latency
);
    timeunit 1ns;
    timeprecision 1ns;
    import sdct_pkg::*;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire [2:0] op = {cmd_pin.ras_n, cmd_pin.cas_n, cmd_pin.we_n};
    wire go = !cmd_pin.cs_n && cke_pin && !suspended;
    wire [3:0] m = din_pin.dqm;
    sequence s_rd2;
        go && op == SDCT_C_RD && read_latency == SDCT_LAT_TWO
            ##1 $stable(m) [*3];
    endsequence
    property p_wr;
        go && op == SDCT_C_WR |-> ##3 wr_strobe == ~$past(m, 3);
    endproperty
    a_wr: assert property (p_wr) else $error("write strobe");
    property p_wc;
        $rose(|wr_strobe) |-> $past(!cmd_pin.cs_n && op == SDCT_C_WR, 3);
    endproperty
    a_wc: assert property (p_wc) else $error("stray strobe");
    property p_rq;
        go && op == SDCT_C_RD |-> ##3 rd_req;
    endproperty
    a_rq: assert property (p_rq) else $error("read request");
    property p_oe;
        s_rd2 |-> ##2 dq_oe_n == $past(m, 2);
    endproperty
    a_oe: assert property (p_oe) else $error("read mask");
    property p_hz;
        go && op == SDCT_C_PRE |-> ##5
            (read_latency == SDCT_LAT_THREE || &dq_oe_n) ##1 &dq_oe_n;
    endproperty
    a_hz: assert property (p_hz) else $error("float");
    property p_lt;
        go && op == SDCT_C_LMR
            && cmd_pin.addr[SDCT_LAT_LSB +: 2] == SDCT_LAT_TWO
            |-> ##3 read_latency == SDCT_LAT_TWO;
    endproperty
    a_lt: assert property (p_lt) else $error("latency");
    property p_si;
        $fell(cke_pin) && !suspended |-> ##2 !suspended ##1 suspended;
    endproperty
    a_si: assert property (p_si) else $error("suspend");
    property p_so;
        $rose(cke_pin) && suspended |-> ##2 suspended ##1 !suspended;
    endproperty
    a_so: assert property (p_so) else $error("resume");
endmodule : sdct_chk

bind sdct_core sdct_chk u_chk (.*);

// >>> testbench/sdct_array.sv
// array stand-in: fixed word the cycle after a read request
// assumes the core asks once per word; idle bus keeps toggling
module sdct_array #(
    parameter logic [31:0] WORD = 32'h5a3c_96e1
) (
    input logic clk_sys,
    input logic rd_req,
    output logic [31:0] rd_word = 32'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge clk_sys)
        rd_word <= rd_req ? WORD : ~rd_word;
endmodule : sdct_array

// >>> testbench/tb.sv
// bench: write rows, then reads, latency load, suspend
// assumes the array stand-in returns its fixed word
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sdct_pkg::*;
    localparam logic [31:0] RD_WORD = 32'h5a3c_96e1;
    localparam int PERIOD = 40;
    // power-up pause rounded up to whole cycles
    localparam int PWR_WAIT = (100_000 + PERIOD - 1) / PERIOD;
    logic clk_sys = 0;
    logic rst = 1;
    logic cke_pin = 1;
    sdct_cmd_t cmd_pin = '1;
    sdct_data_t din_pin = '0;
    logic [31:0] rd_word, dq_out, wr_word;
    logic [3:0] dq_oe_n, wr_strobe;
    logic rd_req, suspended;
    logic [1:0] read_latency;
    int bad_count = 0;
    int cmp_count = 0;
    sdct_data_t rows[4] = '{'{32'h1234_5678, 4'h0}, '{32'h0f0f_f0f0, 4'h5},
        '{32'hffff_0000, 4'ha}, '{32'h8000_0001, 4'h3}};
    sdct_core dut (.*);
    sdct_array #(.WORD(RD_WORD)) u_arr (.*);
    initial forever #(PERIOD / 2) clk_sys = ~clk_sys;
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic issue(logic cs, logic [2:0] op, logic [11:0] a,
        sdct_data_t d, int w);
        cmd_pin <= '{cs, op[2], op[1], op[0], 2'h0, a};
        din_pin <= d;
        @(negedge clk_sys);
        if (w > 1)
        begin
            cmd_pin.cs_n <= 1'b1;
            repeat (w - 1) @(negedge clk_sys);
        end
    endtask : issue
    task automatic report_and_stop();
        $display("compared %0d bad %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #((PWR_WAIT + 400) * PERIOD);
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (3) @(negedge clk_sys);
        chk("oe_rst", 4'hf, dq_oe_n);
        chk("lat_rst", SDCT_LAT_RESET, read_latency);
        rst <= 1'b0;
        repeat (PWR_WAIT) @(negedge clk_sys);
        issue(1'b0, SDCT_C_REF, 12'h0, '{32'h0, 4'h0}, 2);
        issue(1'b0, SDCT_C_REF, 12'h0, '{32'h0, 4'h0}, 2);
        foreach (rows[i])
        begin
            fork
                automatic int k = i;
                begin
                    repeat (3) @(negedge clk_sys);
                    chk("strobe", 4'(~rows[k].dqm), wr_strobe);
                    chk("word", rows[k].dq, wr_word);
                end
            join_none
            issue(1'b0, SDCT_C_WR, 12'h0, rows[i], 1);
        end
        issue(1'b0, SDCT_C_STOP, 12'h0, '{32'h0, 4'hf}, 4);
        issue(1'b0, SDCT_C_ACT, 12'h0, '{32'h0, 4'h0}, 6);
        issue(1'b1, SDCT_C_WR, 12'h0, '{32'h0, 4'h0}, 3);
        chk("cs_high", 4'h0, wr_strobe);
        issue(1'b0, SDCT_C_RD, 12'h0, '{32'h0, 4'h5}, 6);
        chk("oe_l3", 4'h5, dq_oe_n);
        chk("rd_l3", RD_WORD & 32'hff00_ff00, dq_out & 32'hff00_ff00);
        issue(1'b0, SDCT_C_PRE, 12'h0, '{32'h0, 4'h5}, 6);
        chk("hiz_l3", 4'hf, dq_oe_n);
        issue(1'b0, SDCT_C_LMR, 12'h020, '{32'h0, 4'h0}, 4);
        chk("lat", 2'h2, read_latency);
        issue(1'b0, SDCT_C_RD, 12'h0, '{32'h0, 4'h0}, 5);
        chk("rd_l2", RD_WORD, dq_out);
        issue(1'b0, SDCT_C_PRE, 12'h0, '{32'h0, 4'h0}, 5);
        chk("hiz_l2", 4'hf, dq_oe_n);
        cke_pin <= 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("susp", 1'b1, suspended);
        issue(1'b0, SDCT_C_WR, 12'h0, '{32'h0, 4'h0}, 3);
        chk("susp_wr", 4'h0, wr_strobe);
        cke_pin <= 1'b1;
        repeat (4) @(negedge clk_sys);
        chk("resume", 1'b0, suspended);
        rst <= 1'b1;
        @(negedge clk_sys);
        chk("lat_rst2", SDCT_LAT_RESET, read_latency);
        chk("oe_rst2", 4'hf, dq_oe_n);
        chk("susp_rst2", 1'b0, suspended);
        rst <= 1'b0;
        issue(1'b0, SDCT_C_RD, 12'h0, '{32'h0, 4'h0}, 1);
        issue(1'b0, SDCT_C_PRE, 12'h0, '{32'h0, 4'h0}, 5);
        chk("rd_pre", RD_WORD, dq_out);
        chk("oe_pre", 4'h0, dq_oe_n);
        @(negedge clk_sys);
        chk("hiz_pre", 4'hf, dq_oe_n);
        report_and_stop();
    end
endmodule : tb
